// ==== axis_stop_defines.svh ====
`ifndef AXIS_STOP_DEFINES_SVH
`define AXIS_STOP_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------
`define OFS_MODE     8'h00
`define OFS_ENV_ONE  8'h04
`define OFS_ENV_TWO  8'h08
`define OFS_ENV_THR  8'h0c
`define OFS_COMMAND  8'h10
`define OFS_MOVE     8'h14
`define OFS_REMAIN   8'h18
`define OFS_CNT_ONE  8'h1c
`define OFS_CNT_TWO  8'h20
`define OFS_ERROR    8'h24
`define OFS_STATUS   8'h28

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define MODE_OVR_TWO    0
`define MODE_STOP_IN_EN 24
`define MODE_STOP_OUT   25
`define ENV1_STOP_DECEL 19
`define ENV1_FTM_LO     20
`define ENV1_FTM_HI     21
`define ENV1_FILT_SEL   26
`define ENV2_CMD_OUT    13
`define ENV2_ENC_OFF    14
`define ENV2_EIM_LO     16
`define ENV2_EIM_HI     17
`define ENV2_ENC_FILT   18
`define ENV2_ENC_DIR    19
`define ENV3_SRC_ONE    0
`define ENV3_SRC_TWO    1
`define ERR_STOP_LINE   3
`define ERR_EMERGENCY   4
`define ERR_ENCODER     7
`define STS_RUNNING     0
`define STS_DECEL       1
`define STS_INDEX       2
`define STS_WAIT_START  3
`define STS_STOP_LOW    6
`define STS_EMG_LOW     7

// ----------------------------------------------------------------
// Commands and reset values.
// ----------------------------------------------------------------
`define CMD_START       8'h01
`define CMD_STOP        8'h02
`define CMD_EMERGENCY   8'h05
`define CMD_SIM_STOP    8'h07
`define RST_WORD        32'h0000_0000

// ----------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------
`define CLK_MHZ         200
`define CYC_MIN(ns)     ((((ns) * `CLK_MHZ) + 999) / 1000)
`define FILT_FAST_NS    100
`define ENC_SLOW_NS     150
`define FILT_3U2_NS     3200
`define FILT_25U_NS     25000
`define FILT_200U_NS    200000
`define FILT_1M6_NS     1600000
`define STOP_PULSE_CYC  4'h8

`endif

// ==== axis_stop_pkg.sv ====
package axis_stop_pkg;

	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} axi_rsp_s;

	typedef enum logic [1:0] {
		AXIS_IDLE,
		AXIS_RUN,
		AXIS_DECEL
	} axis_mode_e;

	typedef struct packed {
		logic        stop_m;
		logic        stop_s;
		logic        emg_m;
		logic        emg_s;
		logic        pcs_m;
		logic        pcs_s;
		logic [2:0]  enc_m;
		logic [2:0]  enc_s;
		logic [2:0]  enc_filt;
		logic [14:0] enc_cnt;
		logic        emg_filt;
		logic [18:0] emg_cnt;
		logic [3:0]  pulse_cnt;
		axis_mode_e  mode;
		logic        wait_pcs;
		logic [31:0] mode_reg;
		logic [31:0] env1;
		logic [31:0] env2;
		logic [31:0] env3;
		logic [31:0] move;
		logic [31:0] remain;
		logic [31:0] cnt1;
		logic [31:0] cnt2;
		logic [7:0]  err;
		logic        aw_got;
		logic [7:0]  aw_addr;
		logic        w_got;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} state_s;

endpackage : axis_stop_pkg

// ==== axis_stop_and_position_counters.sv ====
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "axis_stop_defines.svh"

module axis_stop_and_position_counters #(
	parameter int unsigned FILT_25U_CYC  = `CYC_MIN(`FILT_25U_NS),
	parameter int unsigned FILT_200U_CYC = `CYC_MIN(`FILT_200U_NS),
	parameter int unsigned FILT_1M6_CYC  = `CYC_MIN(`FILT_1M6_NS)
) (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire axis_stop_pkg::axi_req_s axi_req,
	output      axis_stop_pkg::axi_rsp_s axi_rsp,
	input  wire logic                    shared_stop_line_in,
	output      logic                    shared_stop_line_out,
	output      logic                    shared_stop_line_oe,
	input  wire logic                    emergency_input,
	input  wire logic                    encoder_phase_a,
	input  wire logic                    encoder_phase_b,
	input  wire logic                    encoder_index,
	input  wire logic                    command_pulse,
	input  wire logic                    command_dir,
	input  wire logic                    pulse_count_start,
	input  wire logic                    decel_done,
	output      logic                    axis_running,
	output      logic                    axis_decelerating,
	output      logic                    interrupt_n
);

	localparam logic [18:0] FILT_FAST = 19'(`CYC_MIN(`FILT_FAST_NS));
	localparam logic [18:0] FILT_3U2  = 19'(`CYC_MIN(`FILT_3U2_NS));
	localparam logic [4:0]  ENC_FAST  = 5'(`CYC_MIN(`FILT_FAST_NS));
	localparam logic [4:0]  ENC_SLOW  = 5'(`CYC_MIN(`ENC_SLOW_NS));

	axis_stop_pkg::state_s s;
	axis_stop_pkg::state_s next_s;

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	function automatic logic mapped(input logic [7:0] addr);
		case (addr)
			`OFS_MODE, `OFS_ENV_ONE, `OFS_ENV_TWO, `OFS_ENV_THR,
			`OFS_COMMAND, `OFS_MOVE, `OFS_REMAIN, `OFS_CNT_ONE,
			`OFS_CNT_TWO, `OFS_ERROR, `OFS_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction : mapped

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : merge

	// Emergency filter length chosen by the filter select bits.
	function automatic logic [18:0] emg_limit(input logic [31:0] env1);
		if (!env1[`ENV1_FILT_SEL]) begin
			emg_limit = FILT_FAST;
		end else begin
			case (env1[`ENV1_FTM_HI:`ENV1_FTM_LO])
				2'b00: emg_limit = FILT_3U2;
				2'b01: emg_limit = 19'(FILT_25U_CYC);
				2'b10: emg_limit = 19'(FILT_200U_CYC);
				default: emg_limit = 19'(FILT_1M6_CYC);
			endcase
		end
	endfunction : emg_limit

	function automatic logic [31:0] status_word(
		input axis_stop_pkg::state_s st);
		status_word = `RST_WORD;
		status_word[`STS_RUNNING] = st.mode != axis_stop_pkg::AXIS_IDLE;
		status_word[`STS_DECEL] = st.mode == axis_stop_pkg::AXIS_DECEL;
		status_word[`STS_INDEX] = st.enc_filt[2];
		status_word[`STS_WAIT_START] = st.wait_pcs;
		status_word[`STS_STOP_LOW] = !st.stop_s;
		status_word[`STS_EMG_LOW] = !st.emg_filt;
	endfunction : status_word

	function automatic logic [31:0] read_word(
		input axis_stop_pkg::state_s st, input logic [7:0] addr);
		case (addr)
			`OFS_MODE:    read_word = st.mode_reg;
			`OFS_ENV_ONE: read_word = st.env1;
			`OFS_ENV_TWO: read_word = st.env2;
			`OFS_ENV_THR: read_word = st.env3;
			`OFS_MOVE:    read_word = st.move;
			`OFS_REMAIN:  read_word = st.remain;
			`OFS_CNT_ONE: read_word = st.cnt1;
			`OFS_CNT_TWO: read_word = st.cnt2;
			`OFS_ERROR:   read_word = {24'h00_0000, st.err};
			`OFS_STATUS:  read_word = status_word(st);
			default:      read_word = `RST_WORD;
		endcase
	endfunction : read_word

	// ----------------------------------------------------------------
	// Next-state logic.
	// ----------------------------------------------------------------
	always_comb begin
		logic        wr_now;
		logic [7:0]  code;
		logic        do_start;
		logic        do_stop;
		logic        do_emg;
		logic        do_sim;
		logic [4:0]  enc_lim;
		logic [18:0] emg_lim;
		logic [2:0]  old_e;
		logic        ch_a;
		logic        ch_b;
		logic        up;
		logic        cnt_en;
		logic        enc_err;
		logic [31:0] enc_delta;
		logic [31:0] cmd_delta;
		logic        running;
		logic        emg_low;
		logic        pulse_go;
		logic [31:0] rem_dec;

		next_s = s;
		wr_now = 1'b0;
		code = 8'h00;
		do_start = 1'b0;
		do_stop = 1'b0;
		do_emg = 1'b0;
		do_sim = 1'b0;
		up = 1'b0;
		cnt_en = 1'b0;
		enc_err = 1'b0;
		pulse_go = 1'b0;
		rem_dec = s.remain;

		// Two-flop synchronisers in front of the stop line, emergency, pulse count start and encoder pins.
		next_s.stop_m = shared_stop_line_in;
		next_s.stop_s = s.stop_m;
		next_s.emg_m = emergency_input;
		next_s.emg_s = s.emg_m;
		next_s.pcs_m = pulse_count_start;
		next_s.pcs_s = s.pcs_m;
		next_s.enc_m = {encoder_index, encoder_phase_b, encoder_phase_a};
		next_s.enc_s = s.enc_m;

		// A level is accepted once it has stood for the filter length.
		enc_lim = s.env2[`ENV2_ENC_FILT] ? ENC_SLOW : ENC_FAST;
		for (int i = 0; i < 3; i++) begin
			if (s.enc_s[i] == s.enc_filt[i]) begin
				next_s.enc_cnt[i*5 +: 5] = 5'h00;
			end else if (s.enc_cnt[i*5 +: 5] + 5'h01 >= enc_lim) begin
				next_s.enc_filt[i] = s.enc_s[i];
				next_s.enc_cnt[i*5 +: 5] = 5'h00;
			end else begin
				next_s.enc_cnt[i*5 +: 5] = s.enc_cnt[i*5 +: 5] + 5'h01;
			end
		end
		emg_lim = emg_limit(s.env1);
		if (s.emg_s == s.emg_filt) begin
			next_s.emg_cnt = 19'h0_0000;
		end else if (s.emg_cnt + 19'h0_0001 >= emg_lim) begin
			next_s.emg_filt = s.emg_s;
			next_s.emg_cnt = 19'h0_0000;
		end else begin
			next_s.emg_cnt = s.emg_cnt + 19'h0_0001;
		end

		// Encoder decoding on the filtered phases.
		old_e = s.enc_filt;
		ch_a = old_e[0] ^ next_s.enc_filt[0];
		ch_b = old_e[1] ^ next_s.enc_filt[1];
		case (s.env2[`ENV2_EIM_HI:`ENV2_EIM_LO])
			2'b11: begin
				enc_err = ch_a && ch_b && next_s.enc_filt[0]
					&& next_s.enc_filt[1];
				cnt_en = !enc_err && ((ch_a && next_s.enc_filt[0])
					|| (ch_b && next_s.enc_filt[1]));
				up = ch_a && next_s.enc_filt[0];
			end
			default: begin
				enc_err = ch_a && ch_b;
				up = next_s.enc_filt[0] ^ old_e[1];
				case (s.env2[`ENV2_EIM_HI:`ENV2_EIM_LO])
					2'b00: cnt_en = ch_a && !ch_b && !old_e[1];
					2'b01: cnt_en = ch_a && !ch_b;
					default: cnt_en = (ch_a || ch_b) && !enc_err;
				endcase
			end
		endcase
		if (s.env2[`ENV2_ENC_OFF]) begin
			cnt_en = 1'b0;
			enc_err = 1'b0;
		end
		up = up ^ s.env2[`ENV2_ENC_DIR];
		enc_delta = cnt_en ? (up ? 32'h0000_0001 : 32'hffff_ffff)
			: 32'h0000_0000;
		cmd_delta = command_pulse ? (command_dir ? 32'hffff_ffff
			: 32'h0000_0001) : 32'h0000_0000;

		// Counters wrap naturally at 32 bits.
		next_s.cnt1 = s.cnt1 + (s.env3[`ENV3_SRC_ONE] ? enc_delta
			: cmd_delta);
		next_s.cnt2 = s.cnt2 + (s.env3[`ENV3_SRC_TWO] ? cmd_delta
			: enc_delta);

		// Register bus: address and data may arrive in either order.
		if (axi_req.awvalid && !s.aw_got && !s.bvalid) begin
			next_s.aw_got = 1'b1;
			next_s.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && !s.w_got && !s.bvalid) begin
			next_s.w_got = 1'b1;
			next_s.wdata = axi_req.wdata;
			next_s.wstrb = axi_req.wstrb;
		end
		if (s.bvalid && axi_req.bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.aw_got && s.w_got) begin
			wr_now = mapped(s.aw_addr);
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = wr_now ? 2'b00 : 2'b10;
		end
		if (wr_now) begin
			case (s.aw_addr)
				`OFS_MODE: next_s.mode_reg = merge(s.mode_reg, s.wdata,
					s.wstrb);
				`OFS_ENV_ONE: next_s.env1 = merge(s.env1, s.wdata, s.wstrb);
				`OFS_ENV_TWO: next_s.env2 = merge(s.env2, s.wdata, s.wstrb);
				`OFS_ENV_THR: next_s.env3 = merge(s.env3, s.wdata, s.wstrb);
				`OFS_MOVE: next_s.move = merge(s.move, s.wdata, s.wstrb);
				`OFS_CNT_ONE: next_s.cnt1 = merge(s.cnt1, s.wdata, s.wstrb);
				`OFS_CNT_TWO: next_s.cnt2 = merge(s.cnt2, s.wdata, s.wstrb);
				`OFS_ERROR: begin
					if (s.wstrb[0]) begin
						next_s.err = s.err & ~s.wdata[7:0];
					end
				end
				`OFS_COMMAND: begin
					if (s.wstrb[0]) begin
						code = s.wdata[7:0];
					end
				end
				default: begin
				end
			endcase
		end
		do_start = code == `CMD_START;
		do_stop = code == `CMD_STOP;
		do_emg = code == `CMD_EMERGENCY;
		do_sim = code == `CMD_SIM_STOP;

		if (axi_req.arvalid && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = read_word(s, axi_req.araddr);
			next_s.rresp = mapped(axi_req.araddr) ? 2'b00 : 2'b10;
		end else if (s.rvalid && axi_req.rready) begin
			next_s.rvalid = 1'b0;
		end

		// Axis sequencing; error flags are set after the clears above.
		running = s.mode != axis_stop_pkg::AXIS_IDLE;
		emg_low = !s.emg_filt;
		if (enc_err) begin
			next_s.err[`ERR_ENCODER] = 1'b1;
		end
		if (do_emg || emg_low) begin
			next_s.err[`ERR_EMERGENCY] = 1'b1;
			next_s.mode = axis_stop_pkg::AXIS_IDLE;
			next_s.wait_pcs = 1'b0;
			pulse_go = running && s.mode_reg[`MODE_STOP_OUT];
		end else if (s.mode_reg[`MODE_STOP_IN_EN] && !s.stop_s
			&& running) begin
			next_s.err[`ERR_STOP_LINE] = 1'b1;
			if (s.env1[`ENV1_STOP_DECEL]) begin
				next_s.mode = axis_stop_pkg::AXIS_DECEL;
			end else begin
				next_s.mode = axis_stop_pkg::AXIS_IDLE;
			end
		end else if (do_stop && running) begin
			next_s.mode = axis_stop_pkg::AXIS_IDLE;
			next_s.wait_pcs = 1'b0;
			pulse_go = s.env2[`ENV2_CMD_OUT]
				&& s.mode_reg[`MODE_STOP_OUT];
		end else if (do_start && !running) begin
			next_s.remain = s.move[31] ? -s.move : s.move;
			next_s.mode = axis_stop_pkg::AXIS_RUN;
			next_s.wait_pcs = s.mode_reg[`MODE_OVR_TWO];
		end else if (running) begin
			if (s.wait_pcs && s.pcs_s) begin
				next_s.wait_pcs = 1'b0;
			end
			if (command_pulse && !s.wait_pcs) begin
				rem_dec = s.remain - 32'h0000_0001;
				next_s.remain = rem_dec;
			end
			if (rem_dec == 32'h0000_0000 && !s.wait_pcs) begin
				next_s.mode = axis_stop_pkg::AXIS_IDLE;
			end else if (s.mode == axis_stop_pkg::AXIS_DECEL
				&& decel_done) begin
				next_s.mode = axis_stop_pkg::AXIS_IDLE;
			end
		end

		// One-shot low pulse on the shared line; it is read back through
		// the synchroniser, so the issuing axis stops as well when MODE_STOP_IN_EN is set.
		if (do_sim || pulse_go) begin
			next_s.pulse_cnt = `STOP_PULSE_CYC;
		end else if (s.pulse_cnt != 4'h0) begin
			next_s.pulse_cnt = s.pulse_cnt - 4'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.stop_m <= 1'b1;
			s.stop_s <= 1'b1;
			s.emg_m <= 1'b1;
			s.emg_s <= 1'b1;
			s.emg_filt <= 1'b1;
			s.mode <= axis_stop_pkg::AXIS_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs.
	// ----------------------------------------------------------------
	assign shared_stop_line_out = 1'b0;
	assign shared_stop_line_oe  = s.pulse_cnt != 4'h0;
	assign axis_running = s.mode != axis_stop_pkg::AXIS_IDLE;
	assign axis_decelerating = s.mode == axis_stop_pkg::AXIS_DECEL;
	assign interrupt_n = ~|s.err;

	assign axi_rsp.awready = !s.aw_got && !s.bvalid;
	assign axi_rsp.wready  = !s.w_got && !s.bvalid;
	assign axi_rsp.bvalid  = s.bvalid;
	assign axi_rsp.bresp   = s.bresp;
	assign axi_rsp.arready = !s.rvalid;
	assign axi_rsp.rvalid  = s.rvalid;
	assign axi_rsp.rdata   = s.rdata;
	assign axi_rsp.rresp   = s.rresp;

endmodule : axis_stop_and_position_counters

// ==== axis_far_side.sv ====
`timescale 1ns/100ps

module axis_far_side (
	input  wire logic aclk,
	input  wire logic stop_oe,
	output      logic stop_level,
	output      logic phase_a,
	output      logic phase_b
);
	// Forward quadrature states, two bits each as {a, b}.
	localparam logic [7:0] QSEQ = 8'b01_11_10_00;
	logic ext_low;

	// The wire has a pull-up, so it is low while any party pulls it.
	assign stop_level = !(stop_oe || ext_low);

	initial begin
		ext_low = 1'b0;
		phase_a = 1'b0;
		phase_b = 1'b0;
	end

	task automatic ext_pulse(input int n);
		@(posedge aclk);
		ext_low <= 1'b1;
		repeat ((n < 4) ? 4 : n) @(posedge aclk);
		ext_low <= 1'b0;
	endtask : ext_pulse

	task automatic quad(input int cyc, input logic back, input int hold);
		int k;
		for (int i = 1; i <= 4 * cyc; i++) begin
			k = back ? (4 - i % 4) % 4 : i % 4;
			@(posedge aclk);
			{phase_a, phase_b} <= QSEQ[2 * k +: 2];
			repeat (hold - 1) @(posedge aclk);
		end
	endtask : quad

	// Both phases change together, which a real encoder never does.
	task automatic flip(input int hold);
		@(posedge aclk);
		{phase_a, phase_b} <= ~{phase_a, phase_b};
		repeat (hold - 1) @(posedge aclk);
	endtask : flip
endmodule : axis_far_side

// ==== axis_stop_monitor.sv ====
`timescale 1ns/100ps
`include "axis_stop_defines.svh"

module axis_stop_monitor (
	input wire logic                    aclk,
	input wire logic                    aresetn,
	input wire axis_stop_pkg::axi_req_s axi_req,
	input wire axis_stop_pkg::axi_rsp_s axi_rsp,
	input wire logic                    shared_stop_line_out,
	input wire logic                    shared_stop_line_oe,
	input wire logic                    emergency_input,
	input wire logic                    axis_running,
	input wire logic                    axis_decelerating,
	input wire logic                    interrupt_n
);
	localparam int EMG_LIMIT = 700;
	logic [9:0] emg_low_cnt;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Counts the cycles for which the emergency input has stayed low.
	always_ff @(posedge aclk) begin
		if (!aresetn || emergency_input)
			emg_low_cnt <= 10'h000;
		else if (emg_low_cnt != 10'h3ff)
			emg_low_cnt <= emg_low_cnt + 10'h001;
	end

	sequence wr_taken;
		axi_req.awvalid && axi_rsp.awready &&
		axi_req.wvalid && axi_rsp.wready;
	endsequence
	sequence sim_stop_wr;
		wr_taken ##0 (axi_req.awaddr == `OFS_COMMAND &&
			axi_req.wdata[7:0] == `CMD_SIM_STOP);
	endsequence

	chk_write_answer: assert property (
		wr_taken |-> ##2 axi_rsp.bvalid)
		else $error("write answer late");
	chk_read_answer: assert property (
		axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("read answer late");
	chk_write_busy: assert property (
		axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
		else $error("write taken while answer pending");
	chk_cmd_pulse: assert property (
		sim_stop_wr |-> ##[1:3] shared_stop_line_oe)
		else $error("no stop pulse after command");
	chk_pulse_width: assert property (
		$rose(shared_stop_line_oe) |-> shared_stop_line_oe[*8])
		else $error("stop pulse too short");
	chk_pulse_end: assert property (
		$fell(shared_stop_line_oe) |-> $past(shared_stop_line_oe, 8))
		else $error("stop pulse length wrong");
	chk_drive_low: assert property (
		shared_stop_line_oe |-> !shared_stop_line_out)
		else $error("stop wire driven high");
	chk_decel_run: assert property (
		axis_decelerating |-> axis_running)
		else $error("decelerating while not running");
	chk_emg_halt: assert property (
		emg_low_cnt >= EMG_LIMIT |-> !axis_running && !interrupt_n)
		else $error("axis active under emergency");
endmodule : axis_stop_monitor

bind axis_stop_and_position_counters axis_stop_monitor i_mon (
	.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
	.axi_rsp(axi_rsp), .shared_stop_line_out(shared_stop_line_out),
	.shared_stop_line_oe(shared_stop_line_oe),
	.emergency_input(emergency_input), .axis_running(axis_running),
	.axis_decelerating(axis_decelerating), .interrupt_n(interrupt_n));

// ==== axis_stop_and_position_counters_tb.sv ====
`timescale 1ns/100ps
`include "axis_stop_defines.svh"

module axis_stop_and_position_counters_tb;
	axis_stop_pkg::axi_req_s req;
	axis_stop_pkg::axi_rsp_s rsp;
	logic        aclk, aresetn, stop_level, stop_oe, emergency_input;
	logic        enc_a, enc_b, command_pulse, command_dir;
	logic        pulse_count_start, decel_done, enc_z;
	logic        axis_running, axis_decelerating, interrupt_n;
	logic [31:0] seed, rd_data, want;
	logic [1:0]  resp;
	logic [3:0]  strb;
	int          bad_count, comparisons, c, n;

	axis_stop_and_position_counters #(.FILT_25U_CYC(40),
		.FILT_200U_CYC(60), .FILT_1M6_CYC(80)) i_dut (
		.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.shared_stop_line_in(stop_level), .shared_stop_line_out(),
		.shared_stop_line_oe(stop_oe),
		.emergency_input(emergency_input),
		.encoder_phase_a(enc_a), .encoder_phase_b(enc_b),
		.encoder_index(enc_z), .command_pulse(command_pulse),
		.command_dir(command_dir),
		.pulse_count_start(pulse_count_start),
		.decel_done(decel_done), .axis_running(axis_running),
		.axis_decelerating(axis_decelerating),
		.interrupt_n(interrupt_n));
	axis_far_side i_far (.aclk(aclk), .stop_oe(stop_oe),
		.stop_level(stop_level), .phase_a(enc_a), .phase_b(enc_b));

	always #2.5 aclk = ~aclk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs

	function automatic logic [31:0] byte_mask(input logic [3:0] b);
		return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
	endfunction : byte_mask

	function automatic int steps(input logic [1:0] m);
		return (m == 2'b11) ? 0 : (1 << m);
	endfunction : steps

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] got, input logic [31:0] ev);
		comparisons++;
		if (got !== ev) begin
			bad_count++;
			$display("mismatch at %0t got %h want %h", $time, got, ev);
		end
	endtask : check

	task automatic bchk(input logic got, input logic ev);
		check({31'h0, got}, {31'h0, ev});
	endtask : bchk

	task automatic tick(input int k);
		repeat (k) @(posedge aclk);
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= strb;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		for (int i = 0; i < 64 && !done; i++) begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready)
				req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready)
				req.wvalid <= 1'b0;
			if (rsp.bvalid === 1'b1) begin
				resp = rsp.bresp;
				req.bready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done)
			bad_count++;
		if (!done)
			final_report();
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] ev);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		for (int i = 0; i < 64 && !done; i++) begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready)
				req.arvalid <= 1'b0;
			if (rsp.rvalid === 1'b1) begin
				rd_data = rsp.rdata;
				resp = rsp.rresp;
				req.rready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) begin
			bad_count++;
			final_report();
		end else begin
			check(rd_data & m, ev);
		end
	endtask : rchk

	task automatic cmd(input logic [7:0] code);
		wr(`OFS_COMMAND, {24'h0, code});
	endtask : cmd

	// Counts the stop pulse cycles in the 30 cycles from the start of a command write.
	task automatic cmd_oe(input logic [7:0] code, output int cnt);
		cnt = 0;
		fork
			cmd(code);
			repeat (30) begin
				@(posedge aclk);
				cnt += (stop_oe === 1'b1) ? 1 : 0;
			end
		join
	endtask : cmd_oe

	task automatic pulses(input int k, input logic dir);
		repeat (k) begin
			@(posedge aclk);
			command_pulse <= 1'b1;
			command_dir <= dir;
			@(posedge aclk);
			command_pulse <= 1'b0;
		end
	endtask : pulses

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		req = '0;
		emergency_input = 1'b1;
		command_pulse = 1'b0;
		command_dir = 1'b0;
		pulse_count_start = 1'b0;
		decel_done = 1'b0;
		enc_z = 1'b0;
		strb = 4'hf;
		seed = 32'h4;
		bad_count = 0;
		comparisons = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a <= 40; a += 4)
			rchk(8'(a), 32'hffff_ffff, 32'h0);
		rchk(8'h40, 32'hffff_ffff, 32'h0);
		check({30'h0, resp}, 32'h2);
		wr(8'h40, 32'hffff_ffff);
		check({30'h0, resp}, 32'h2);
		seed = xs(seed);
		wr(`OFS_MOVE, 32'h0);
		strb = seed[3:0];
		wr(`OFS_MOVE, seed);
		strb = 4'hf;
		rchk(`OFS_MOVE, 32'hffff_ffff, seed & byte_mask(seed[3:0]));
		$display("test registers done");
		seed = xs(seed);
		wr(`OFS_MOVE, {4'h1, seed[27:0]});
		cmd(`CMD_START);
		fork
			i_far.ext_pulse(30);
			begin
				tick(4);
				rchk(`OFS_STATUS, 32'h40, 32'h40);
			end
		join
		tick(2);
		rchk(`OFS_STATUS, 32'h40, 32'h0);
		bchk(axis_running, 1'b1);
		wr(`OFS_MODE, 32'h0100_0000);
		i_far.ext_pulse(4);
		tick(6);
		bchk(axis_running, 1'b0);
		rchk(`OFS_ERROR, 32'h08, 32'h08);
		wr(`OFS_ERROR, 32'hff);
		rchk(`OFS_ERROR, 32'hff, 32'h0);
		wr(`OFS_ENV_ONE, 32'h0008_0000);
		cmd(`CMD_START);
		i_far.ext_pulse(4);
		tick(6);
		bchk(axis_decelerating, 1'b1);
		decel_done <= 1'b1;
		tick(1);
		decel_done <= 1'b0;
		tick(3);
		bchk(axis_running, 1'b0);
		wr(`OFS_ENV_ONE, 32'h0);
		cmd(`CMD_START);
		cmd_oe(`CMD_SIM_STOP, c);
		check(c, 8);
		bchk(axis_running, 1'b0);
		cmd(`CMD_START);
		cmd_oe(`CMD_STOP, c);
		check(c, 0);
		bchk(axis_running, 1'b0);
		wr(`OFS_MODE, 32'h0300_0000);
		wr(`OFS_ENV_TWO, 32'h0000_2000);
		cmd(`CMD_START);
		cmd_oe(`CMD_STOP, c);
		check(c, 8);
		cmd(`CMD_START);
		cmd_oe(`CMD_EMERGENCY, c);
		check(c, 8);
		bchk(axis_running, 1'b0);
		rchk(`OFS_ERROR, 32'h10, 32'h10);
		bchk(interrupt_n, 1'b0);
		wr(`OFS_ERROR, 32'hff);
		tick(2);
		bchk(interrupt_n, 1'b1);
		$display("test stop line done");
		wr(`OFS_MODE, 32'h0);
		wr(`OFS_ENV_ONE, 32'h0400_0000);
		cmd(`CMD_START);
		emergency_input <= 1'b0;
		tick(100);
		bchk(axis_running, 1'b1);
		tick(700);
		bchk(axis_running, 1'b0);
		rchk(`OFS_STATUS, 32'h80, 32'h80);
		cmd(`CMD_START);
		tick(4);
		bchk(axis_running, 1'b0);
		emergency_input <= 1'b1;
		tick(700);
		rchk(`OFS_STATUS, 32'h80, 32'h0);
		for (int f = 1; f < 4; f++) begin
			wr(`OFS_ENV_ONE, {5'h0, 1'b1, 4'h0, 2'(f), 20'h0});
			cmd(`CMD_START);
			emergency_input <= 1'b0;
			tick(10 + 20 * f);
			bchk(axis_running, 1'b1);
			tick(20);
			bchk(axis_running, 1'b0);
			emergency_input <= 1'b1;
			tick(100);
		end
		wr(`OFS_ERROR, 32'hff);
		tick(2);
		bchk(interrupt_n, 1'b1);
		wr(`OFS_ENV_ONE, 32'h0);
		$display("test emergency done");
		wr(`OFS_ENV_THR, 32'h2);
		wr(`OFS_CNT_ONE, 32'h0);
		wr(`OFS_CNT_TWO, 32'h0);
		wr(`OFS_MOVE, 32'hffff_ff00);
		cmd(`CMD_START);
		seed = xs(seed);
		n = int'(seed[2:0]) + 1;
		pulses(n, seed[3]);
		tick(2);
		rchk(`OFS_REMAIN, 32'hffff_ffff, 32'(256 - n));
		want = seed[3] ? 32'(-n) : 32'(n);
		rchk(`OFS_CNT_ONE, 32'hffff_ffff, want);
		rchk(`OFS_CNT_TWO, 32'hffff_ffff, want);
		cmd(`CMD_STOP);
		wr(`OFS_MODE, 32'h1);
		wr(`OFS_MOVE, 32'h5);
		cmd(`CMD_START);
		pulses(3, 1'b0);
		rchk(`OFS_REMAIN, 32'hffff_ffff, 32'h5);
		pulse_count_start <= 1'b1;
		tick(4);
		pulses(2, 1'b0);
		rchk(`OFS_REMAIN, 32'hffff_ffff, 32'h3);
		cmd(`CMD_STOP);
		wr(`OFS_MODE, 32'h0);
		wr(`OFS_ENV_THR, 32'h1);
		for (int k = 0; k < 16; k++) begin
			wr(`OFS_ENV_TWO, {12'h0, k[2], k[3], k[1:0], 16'h0});
			wr(`OFS_CNT_ONE, 32'h0);
			i_far.quad(2, k[3], 40);
			tick(40);
			want = 32'(2 * steps(k[1:0]));
			want = (k[2] ^ k[3]) ? -want : want;
			rchk(`OFS_CNT_ONE, 32'hffff_ffff, want);
		end
		wr(`OFS_ENV_TWO, 32'h0002_4000);
		wr(`OFS_CNT_ONE, 32'h0);
		i_far.quad(1, 1'b0, 40);
		i_far.flip(40);
		tick(40);
		rchk(`OFS_CNT_ONE, 32'hffff_ffff, 32'h0);
		rchk(`OFS_ERROR, 32'h80, 32'h0);
		wr(`OFS_ENV_TWO, 32'h0002_0000);
		i_far.flip(40);
		tick(40);
		rchk(`OFS_ERROR, 32'h80, 32'h80);
		rchk(`OFS_CNT_ONE, 32'hffff_ffff, 32'h0);
		wr(`OFS_ENV_TWO, 32'h0004_0000);
		enc_z <= 1'b1;
		tick(25);
		rchk(`OFS_STATUS, 32'h4, 32'h0);
		tick(10);
		rchk(`OFS_STATUS, 32'h4, 32'h4);
		enc_z <= 1'b0;
		tick(40);
		rchk(`OFS_STATUS, 32'h4, 32'h0);
		$display("test counters done");
		final_report();
	end
endmodule : axis_stop_and_position_counters_tb
